//--- design/vdrc_pkg.sv
/*
  Package for the video DRAM random-port controller: command codes,
  Avalon register offsets, field positions and strobe timing counts.
  Assumes a 40 MHz system clock and a strobe-driven video DRAM outside.
*/
package vdrc_pkg;

  // Clock period in ps and documented strobe times in ns
  localparam int CLK_PS          = 25000;
  localparam int T_STEP_NS       = 25;    // Least gap between strobe edges
  localparam int T_STEP_CYC      = ((T_STEP_NS * 1000) + CLK_PS - 1) / CLK_PS;

  // Register offsets (word index, byte address = 4 * index)
  localparam logic [3:0] REG_CTRL    = 4'h0;  // W: go, command, flags
  localparam logic [3:0] REG_ADDR    = 4'h1;  // W: row [8:0], column [24:16]
  localparam logic [3:0] REG_WDATA   = 4'h2;  // W: data [7:0], mask [15:8]
  localparam logic [3:0] REG_STATUS  = 4'h3;  // R: busy, read data
  localparam logic [3:0] REG_PAGE    = 4'h4;  // Not decoded by vdrc_top; writes to it are dropped

  // Control register fields
  localparam int CTRL_GO       = 0;
  localparam int CTRL_CMD_LSB  = 4;
  localparam int CTRL_MASKED   = 8;   // WE low at row strobe fall
  localparam int CTRL_DELAYED  = 9;   // WE falls after column strobe
  localparam int CTRL_HOLD     = 10;  // Keep row open for page mode

  // Status fields
  localparam int STAT_BUSY     = 8;
  localparam int STAT_OPEN     = 9;

  // Commands
  typedef enum logic [3:0] {
    VDRC_CMD_READ   = 4'h0,
    VDRC_CMD_WRITE  = 4'h1,
    VDRC_CMD_BLOCK  = 4'h2,
    VDRC_CMD_FLASH  = 4'h3,
    VDRC_CMD_LCOLOR = 4'h4,
    VDRC_CMD_LMASK  = 4'h5,
    VDRC_CMD_RDXFER = 4'h6,
    VDRC_CMD_WRXFER = 4'h7,
    VDRC_CMD_SPXFER = 4'h8,
    VDRC_CMD_MRST   = 4'h9
  } vdrc_cmd_t;

  // Pin bundle driven to the DRAM
  typedef struct packed {
    logic       row_strobe_n;
    logic       col_strobe_n;
    logic       transfer_output_enable_n;
    logic       write_enable_n;
    logic       special_function_flag;
    logic       reserved_function_flag;
    logic [8:0] addr;
    logic [7:0] io_out;
    logic       io_oe;
  } vdrc_pins_t;

  localparam vdrc_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                                       9'h000, 8'h00, 1'b0};

endpackage

//--- design/vdrc_top.sv
/*
  Host-side controller for a dual-port video DRAM random port. Software
  posts commands over Avalon-MM; the block sequences the strobes.
  Assumes the DRAM's I/O read data returns on io_in while col strobe low.
*/
// What this block does
// - Write: transfer high, col high, flag low.
// - Delayed write: keep output enable high.
// - Col toggles in open row give page accesses.
// - Block: I/O at col fall, or at WE fall if delayed, masks columns.
// - Transfer: col high, transfer line low.
// - Register cycle: flag at col picks register.
// - Reserved function flag always held low.
// - Transfer direction from WE at row fall.
`timescale 1ns/10ps
module vdrc_top
  import vdrc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output vdrc_pkg::vdrc_pins_t   dram,
  input  wire logic [7:0]        io_in
);
  import vdrc_pkg::*;

  // Last count of one strobe step
  localparam logic [3:0] STEP_LAST = 4'(T_STEP_CYC - 1);
  // Extra column-low cycles while read data crosses the two synchroniser flops
  localparam logic [1:0] SYNC_LAST = 2'h2;

  // Reset release chain
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Pin input synchroniser, two stages before use
  logic [7:0] io_s1_q, io_s2_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
    end else begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,  // Row closed
    S_ROW   = 8'h02,  // Controls set up, row strobe falls next
    S_RFALL = 8'h04,  // Row strobe low, controls latched by device
    S_COL   = 8'h08,  // Column address and flag set up
    S_CFALL = 8'h10,  // Column strobe low
    S_WE    = 8'h20,  // Delayed write enable
    S_OPEN  = 8'h40,  // Row held open for page access
    S_CLOSE = 8'h80   // Row strobe high, precharge
  } vdrc_state_t;

  vdrc_state_t state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [31:0] ctrl_q, ctrl_d;         // Command word
  logic [31:0] addr_q, addr_d;         // Row and column
  logic [15:0] wdat_q, wdat_d;         // Data and mask
  logic [7:0]  rdat_q, rdat_d;         // Captured read data
  logic        pers_q, pers_d;         // Persistent mask believed set
  vdrc_pins_t  pins_q, pins_d;
  logic [31:0] rd_q, rd_d;
  logic        wait_q, wait_d;
  logic [1:0]  rwait_q, rwait_d;       // Read settle count

  vdrc_cmd_t cmd;
  logic      masked, delayed, hold, wr_kind, is_xfer;
  assign cmd     = vdrc_cmd_t'(ctrl_q[CTRL_CMD_LSB +: 4]);
  assign masked  = ctrl_q[CTRL_MASKED];
  assign delayed = ctrl_q[CTRL_DELAYED];
  assign hold    = ctrl_q[CTRL_HOLD];
  // Commands that drive write data at the column strobe
  assign wr_kind = (cmd == VDRC_CMD_WRITE) || (cmd == VDRC_CMD_BLOCK) ||
                   (cmd == VDRC_CMD_LCOLOR) || (cmd == VDRC_CMD_LMASK);
  assign is_xfer = (cmd == VDRC_CMD_RDXFER) || (cmd == VDRC_CMD_WRXFER) ||
                   (cmd == VDRC_CMD_SPXFER);

  // Next-state and pin logic
  always_comb begin
    logic step_done;
    step_done = (cnt_q == STEP_LAST);
    state_d = state_q;
    cnt_d   = step_done ? 4'h0 : cnt_q + 4'h1;
    ctrl_d  = ctrl_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    pers_d  = pers_q;
    pins_d  = pins_q;
    wait_d  = 1'b1;
    rd_d    = rd_q;
    rwait_d = rwait_q;
    pins_d.reserved_function_flag = 1'b0;

    // Bus slave: one waitrequest cycle; read data built in the first cycle,
    // writes land only at the edge where waitrequest is seen low
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      rd_d = (avs_address == REG_STATUS) ?
             {22'h0, state_q == S_OPEN, state_q != S_IDLE, rdat_q} : 32'h0;
    end
    if ((avs_read || avs_write) && !wait_q) begin
      wait_d = 1'b1;
      if (avs_write) begin
        unique case (avs_address)
          REG_CTRL:  if (state_q == S_IDLE) ctrl_d = avs_writedata;
          REG_ADDR:  addr_d = avs_writedata;
          REG_WDATA: wdat_d = avs_writedata[15:0];
          default:   ;
        endcase
      end
    end

    unique case (state_q)
      S_IDLE: begin
        pins_d = PINS_IDLE;
        cnt_d  = 4'h0;
        if (ctrl_q[CTRL_GO]) begin
          ctrl_d[CTRL_GO] = 1'b0;
          state_d = S_ROW;
          // Row address and cycle selecting levels
          pins_d.addr = addr_q[8:0];
          pins_d.col_strobe_n = 1'b1;
          // Transfer line low selects a transfer
          pins_d.transfer_output_enable_n = !is_xfer;
          // Flag high for register, flash and split transfers
          pins_d.special_function_flag = (cmd == VDRC_CMD_LCOLOR) ||
            (cmd == VDRC_CMD_LMASK) || (cmd == VDRC_CMD_FLASH) ||
            (cmd == VDRC_CMD_SPXFER);
          // WE at row fall: mask mode or transfer direction
          pins_d.write_enable_n = !((masked && (cmd == VDRC_CMD_WRITE ||
            cmd == VDRC_CMD_BLOCK || cmd == VDRC_CMD_FLASH ||
            cmd == VDRC_CMD_SPXFER)) || cmd == VDRC_CMD_WRXFER ||
            cmd == VDRC_CMD_FLASH);
          // Mask on I/O at row fall unless persistent
          pins_d.io_out = wdat_q[15:8];
          pins_d.io_oe  = !pins_d.write_enable_n && !pers_q;
          if (cmd == VDRC_CMD_MRST) begin
            // Column-before-row refresh clears persistence
            pins_d.col_strobe_n = 1'b0;
            pins_d.io_oe        = 1'b0;
          end
        end
      end
      S_ROW: if (step_done) begin
        pins_d.row_strobe_n = 1'b0;
        state_d = S_RFALL;
      end
      S_RFALL: if (step_done) begin
        pins_d.io_oe = 1'b0;
        if (cmd == VDRC_CMD_FLASH || is_xfer || cmd == VDRC_CMD_MRST) begin
          // Whole-row operations need no column access
          pins_d.transfer_output_enable_n = 1'b1;
          if (cmd == VDRC_CMD_MRST) pers_d = 1'b0;
          state_d = S_CLOSE;
        end else begin
          pins_d.transfer_output_enable_n = 1'b1;
          // Early write: WE and data set up a full step before the column fall
          pins_d.write_enable_n = !(wr_kind && !delayed);
          pins_d.io_out = (cmd == VDRC_CMD_BLOCK) ? {4'h0, wdat_q[3:0]} : wdat_q[7:0];
          pins_d.io_oe  = wr_kind && !delayed;  // Column mask for block
          state_d = S_COL;
        end
        pins_d.addr = addr_q[24:16];
        // Flag at column fall: block, or colour vs mask register
        pins_d.special_function_flag = (cmd == VDRC_CMD_BLOCK) ||
                                       (cmd == VDRC_CMD_LCOLOR);
      end
      S_COL: if (step_done) begin
        // Read: output enable low for as long as the column strobe is low
        if (!wr_kind) pins_d.transfer_output_enable_n = 1'b0;
        pins_d.col_strobe_n = 1'b0;
        rwait_d = 2'h0;
        state_d = S_CFALL;
      end
      S_CFALL: if (step_done) begin
        if (wr_kind && delayed) begin
          // Delayed write: output enable kept high
          pins_d.transfer_output_enable_n = 1'b1;
          pins_d.io_out = (cmd == VDRC_CMD_BLOCK) ? {4'h0, wdat_q[3:0]} : wdat_q[7:0];
          pins_d.io_oe  = 1'b1;
          state_d = S_WE;
        end else if (!wr_kind && rwait_q != SYNC_LAST) begin
          // Read data still crossing the synchroniser; column stays low
          rwait_d = rwait_q + 2'h1;
        end else begin
          if (!wr_kind) rdat_d = io_s2_q;
          if (cmd == VDRC_CMD_LMASK && wr_kind) pers_d = 1'b1;
          pins_d.col_strobe_n   = 1'b1;
          pins_d.write_enable_n = 1'b1;
          pins_d.io_oe          = 1'b0;
          pins_d.transfer_output_enable_n = 1'b1;
          state_d = hold ? S_OPEN : S_CLOSE;
        end
      end
      S_WE: if (step_done) begin
        pins_d.write_enable_n = 1'b0;
        if (cmd == VDRC_CMD_LMASK) pers_d = 1'b1;
        state_d = S_CFALL;
        ctrl_d[CTRL_DELAYED] = 1'b0;  // Next pass closes the access
      end
      S_OPEN: begin
        // Row stays low; mask from row fall still applies
        if (ctrl_q[CTRL_GO]) begin
          ctrl_d[CTRL_GO] = 1'b0;
          pins_d.addr = addr_q[24:16];
          pins_d.special_function_flag = (cmd == VDRC_CMD_BLOCK);
          // Early page write: WE and data ahead of the column fall
          pins_d.write_enable_n = !(wr_kind && !delayed);
          pins_d.io_out = (cmd == VDRC_CMD_BLOCK) ? {4'h0, wdat_q[3:0]} : wdat_q[7:0];
          pins_d.io_oe  = wr_kind && !delayed;
          state_d = S_COL;
        end else if (!hold) begin
          state_d = S_CLOSE;
        end
        cnt_d = 4'h0;
      end
      S_CLOSE: begin
        pins_d.row_strobe_n = 1'b1;
        pins_d.col_strobe_n = 1'b1;
        pins_d.io_oe = 1'b0;
        if (step_done) state_d = S_IDLE;  // Precharge; refresh done
      end
      default: state_d = S_IDLE;
    endcase
    // Page command written while open takes the new control word
    if (state_q == S_OPEN && avs_write && !wait_q && avs_address == REG_CTRL) begin
      ctrl_d = avs_writedata;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
      cnt_q   <= 4'h0;
      ctrl_q  <= 32'h0;
      addr_q  <= 32'h0;
      wdat_q  <= 16'h0;
      rdat_q  <= 8'h00;
      pers_q  <= 1'b0;
      pins_q  <= PINS_IDLE;
      rd_q    <= 32'h0;
      wait_q  <= 1'b1;
      rwait_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ctrl_q  <= ctrl_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      pers_q  <= pers_d;
      pins_q  <= pins_d;
      rd_q    <= rd_d;
      wait_q  <= wait_d;
      rwait_q <= rwait_d;
    end
  end

  assign dram            = pins_q;
  assign avs_readdata    = rd_q;
  assign avs_waitrequest = wait_q;

  // Checks
  chk_reserved_low: assert property (@(posedge clk) disable iff (!rst_n_q)
    !dram.reserved_function_flag) else $error("reserved flag high");
  chk_early_hiz: assert property (@(posedge clk) disable iff (!rst_n_q)
    $fell(dram.col_strobe_n) && !dram.write_enable_n |-> dram.io_oe || !wr_kind)
    else $error("early write without data");
  chk_delay_oe: assert property (@(posedge clk) disable iff (!rst_n_q)
    dram.io_oe && !dram.row_strobe_n && !dram.col_strobe_n |-> dram.transfer_output_enable_n)
    else $error("driving with output enable low");
  chk_row_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    $fell(dram.row_strobe_n) |-> $stable(dram.transfer_output_enable_n))
    else $error("control moved at row fall");
  // Column fall of an early write; WE must already have been low a sample before
  sequence s_early_col_fall;
    $fell(dram.col_strobe_n) && !dram.write_enable_n;
  endsequence
  chk_we_before_col: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_early_col_fall |-> !$past(dram.write_enable_n))
    else $error("write enable not ahead of column fall");
  // Mask mode without a stored mask needs the mask on the I/O at row fall
  chk_row_mask: assert property (@(posedge clk) disable iff (!rst_n_q)
    $fell(dram.row_strobe_n) && !dram.write_enable_n && !pers_q |-> dram.io_oe)
    else $error("mask not driven at row fall");
endmodule

//--- testbench/vdrc_dram_model.sv
/* Behavioural video DRAM random port with a serial register.
   Assumes the pins come from the controller's registered pin bundle. */
`timescale 1ns/10ps
module vdrc_dram_model
  import vdrc_pkg::*;
(
  input  wire vdrc_pkg::vdrc_pins_t pins,
  output logic [7:0]                io_in,
  output int                        faults
);
  logic [7:0] mem [int];                   // Sparse cells, row*512+col
  logic [7:0] serial_access_memory [512];                   // Serial register
  logic [7:0] color_q, mask_q, pm;         // pm: plane mask of this row cycle
  logic       persist, cas_r, toe_r, we_r, sf_r, sfc;
  logic [8:0] row, col;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  initial begin
    {faults, persist, color_q, mask_q, io_in, cas_r, col} = '0;
    foreach (serial_access_memory[i]) serial_access_memory[i] = 8'h00;
  end
  // Cycle kind latched at row fall and kept for the row cycle
  always @(negedge pins.row_strobe_n) begin
    {cas_r, toe_r, we_r, sf_r, row} = {pins.col_strobe_n, pins.transfer_output_enable_n,
                                       pins.write_enable_n, pins.special_function_flag, pins.addr};
    pm = we_r ? 8'hFF : (persist ? mask_q : (pins.io_oe ? pins.io_out : 8'h00));
    if (!cas_r) persist = 1'b0;            // Column-first refresh drops the stored mask
    else if (!toe_r) for (int c = 0; c < 512; c++) begin // Transfers, direction from WE
      if (we_r) serial_access_memory[c] = rd(row * 512 + c);
      else mem[row * 512 + c] = (rd(row * 512 + c) & ~pm) | (serial_access_memory[c] & pm);
    end
    else if (sf_r && !we_r) for (int c = 0; c < 512; c++) // Flash fill, masked
      mem[row * 512 + c] = (rd(row * 512 + c) & ~pm) | (color_q & pm);
  end
  // Write strobe: data on the I/O at the later of column and WE fall
  task automatic wr();
    logic [7:0] d;
    d = pins.io_out;
    if (!cas_r || !toe_r || (sf_r && !we_r)) return;
    if (!pins.io_oe) faults++;             // Write with nothing driven
    if (sf_r) begin                        // Register cycles; column flag picks colour or mask
      if (sfc) color_q = d;
      else {mask_q, persist} = {d, 1'b1};
    end
    else if (sfc) begin                    // Block of four, low column bits ignored
      for (int c = 0; c < 4; c++) if (d[c])
        mem[row * 512 + (col & 9'h1FC) + c] = (rd(row * 512 + (col & 9'h1FC) + c) & ~pm) | (color_q & pm);
    end
    else mem[row * 512 + col] = (rd(row * 512 + col) & ~pm) | (d & pm);
  endtask
  // Each column fall is a new access in the open row
  always @(negedge pins.col_strobe_n) if (!pins.row_strobe_n) begin
    {col, sfc} = {pins.addr, pins.special_function_flag};
    if (!pins.write_enable_n) wr();        // Early write
  end
  always @(negedge pins.write_enable_n) if (!pins.row_strobe_n && !pins.col_strobe_n) wr(); // Delayed
  // Read data only with OE low and WE high, else a toggling pattern
  always @(pins) begin
    if (pins.reserved_function_flag) faults++;
    if (pins.io_oe && !pins.col_strobe_n && !pins.transfer_output_enable_n && toe_r) faults++;
    #1;
    if (!pins.row_strobe_n && !pins.col_strobe_n && pins.write_enable_n && !pins.transfer_output_enable_n
        && cas_r && toe_r) io_in = sf_r ? (sfc ? color_q : mask_q) : rd(row * 512 + col);
    else io_in = ~io_in;
  end
endmodule

//--- testbench/test_video_dram_ram_port_cycles.sv
/* Self-checking bench: random commands through the Avalon registers,
   read back and compared with a reference memory. Assumes vdrc_top. */
`timescale 1ns/10ps
module test_video_dram_ram_port_cycles;
  import vdrc_pkg::*;
  logic        clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
  logic [7:0]  io_in, color, ref_mem [int];
  vdrc_pins_t  dram;
  int          mismatches = 0, comparisons = 0, cycles = 0, faults, r, k, cl;
  always #12.5 clk = ~clk;
  vdrc_top i_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dram(dram), .io_in(io_in));
  vdrc_dram_model i_dram (.pins(dram), .io_in(io_in), .faults(faults));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  function automatic logic [7:0] ref_rd(int a);
    return ref_mem.exists(a) ? ref_mem[a] : 8'h00;
  endfunction
  task automatic ref_wr(int a, logic [7:0] d, logic [7:0] mk);
    ref_mem[a] = (ref_rd(a) & ~mk) | (d & mk);
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // One access, request held until waitrequest is seen low
  // Waitrequest and read data are taken mid-cycle, as the next rising edge sees them
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic wait_seen;
    @(posedge clk);
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
    do begin
      @(negedge clk);
      wait_seen = avs_waitrequest;
      rd_q = avs_readdata;
      @(posedge clk);
    end while (wait_seen !== 1'b0);
    {avs_read, avs_write} <= 2'b00;
  endtask
  // Post a command, then poll busy
  task automatic cmd(vdrc_cmd_t c, logic [8:0] row, logic [8:0] col, logic [7:0] d, logic [7:0] mk,
                     logic msk, logic dly);
    bus(1'b1, REG_ADDR, {7'h0, col, 7'h0, row});
    bus(1'b1, REG_WDATA, {16'h0, mk, d});
    bus(1'b1, REG_CTRL, {22'h0, dly, msk, c, 4'h1});
    do bus(1'b0, REG_STATUS, 32'h0); while (rd_q[STAT_BUSY] !== 1'b0);
  endtask
  task automatic rdchk(logic [8:0] row, logic [8:0] col);
    cmd(VDRC_CMD_READ, row, col, 8'h00, 8'h00, 1'b0, 1'b0);
    cmp({24'h0, ref_rd(row * 512 + col)}, {24'h0, rd_q[7:0]});
  endtask
  // Page access in row 5 held open; the opening write loads mask 5A at row fall
  task automatic page(vdrc_cmd_t c, logic [8:0] col, logic [7:0] d);
    bus(1'b1, REG_ADDR, {7'h0, col, 7'h0, 9'h005});
    bus(1'b1, REG_WDATA, {16'h0, 8'h5A, d});
    bus(1'b1, REG_CTRL, {21'h0, 1'b1, 1'b0, 1'b1, c, 4'h1});
    do bus(1'b0, REG_STATUS, 32'h0); while (rd_q[STAT_OPEN] !== 1'b1);
  endtask
  initial begin
    r = $urandom(38311);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, 4'hE, 32'h12345678);         // Unmapped write is dropped
    bus(1'b0, 4'hF, 32'h0);
    cmp(32'h0, rd_q);
    // Plain, delayed and masked writes over four rows
    for (k = 0; k < 40; k++) begin
      r = $urandom;
      cmd(VDRC_CMD_WRITE, {7'h0, r[1:0]}, r[10:2], r[20:13], r[28:21], r[11], r[12]);
      ref_wr(r[1:0] * 512 + r[10:2], r[20:13], r[11] ? r[28:21] : 8'hFF);
      rdchk({7'h0, r[1:0]}, r[10:2]);
    end
    // Colour load then masked flash of a whole row
    color = r[7:0];
    cmd(VDRC_CMD_LCOLOR, 9'h010, 9'h000, color, 8'h00, 1'b0, 1'b0);
    cmd(VDRC_CMD_FLASH, 9'h002, 9'h000, 8'h00, 8'h3C, 1'b1, 1'b0);
    for (k = 0; k < 512; k++) ref_wr(1024 + k, color, 8'h3C);
    for (k = 0; k < 512; k++) rdchk(9'h002, k[8:0]);
    // Block writes in all mask and timing variants
    for (k = 0; k < 4; k++) begin
      r = $urandom;
      cmd(VDRC_CMD_BLOCK, 9'h003, r[8:0], {4'h0, r[12:9]}, r[20:13], k[0], k[1]);
      for (cl = 0; cl < 4; cl++) if (r[9 + cl]) ref_wr(1536 + (r[8:0] & 9'h1FC) + cl, color, k[0] ? r[20:13] : 8'hFF);
      for (cl = 0; cl < 4; cl++) rdchk(9'h003, (r[8:0] & 9'h1FC) + cl[8:0]);
    end
    // Stored mask overrides the posted one until the reset refresh
    cmd(VDRC_CMD_LMASK, 9'h000, 9'h000, 8'h0F, 8'h00, 1'b0, 1'b0);
    cmd(VDRC_CMD_WRITE, 9'h000, 9'h007, 8'hFF, 8'hF0, 1'b1, 1'b0);
    ref_wr(7, 8'hFF, 8'h0F);
    rdchk(9'h000, 9'h007);
    cmd(VDRC_CMD_MRST, 9'h000, 9'h000, 8'h00, 8'h00, 1'b0, 1'b0);
    cmd(VDRC_CMD_WRITE, 9'h000, 9'h007, 8'h00, 8'hF0, 1'b1, 1'b0);
    ref_wr(7, 8'h00, 8'hF0);
    rdchk(9'h000, 9'h007);
    // Row to serial register, then masked back into rows 31 and 30
    cmd(VDRC_CMD_RDXFER, 9'h002, 9'h000, 8'h00, 8'h00, 1'b0, 1'b0);
    cmd(VDRC_CMD_WRXFER, 9'h01F, 9'h000, 8'h00, 8'h81, 1'b1, 1'b0);
    cmd(VDRC_CMD_SPXFER, 9'h01E, 9'h000, 8'h00, 8'h18, 1'b1, 1'b0);
    for (k = 0; k < 512; k += 17) begin
      ref_wr(31 * 512 + k, ref_rd(1024 + k), 8'h81);
      ref_wr(30 * 512 + k, ref_rd(1024 + k), 8'h18);
      rdchk(9'h01F, k[8:0]);
      rdchk(9'h01E, k[8:0]);
    end
    // Page mode: the row-fall mask covers every column of the open row
    page(VDRC_CMD_WRITE, 9'h010, r[7:0]);
    page(VDRC_CMD_WRITE, 9'h1FF, r[15:8]);
    ref_wr(5 * 512 + 16, r[7:0], 8'h5A);
    ref_wr(5 * 512 + 511, r[15:8], 8'h5A);
    page(VDRC_CMD_READ, 9'h010, 8'h00);
    cmp({24'h0, ref_rd(5 * 512 + 16)}, {24'h0, rd_q[7:0]});
    page(VDRC_CMD_READ, 9'h1FF, 8'h00);
    cmp({24'h0, ref_rd(5 * 512 + 511)}, {24'h0, rd_q[7:0]});
    bus(1'b1, REG_CTRL, 32'h0);            // Hold dropped: row closes
    do bus(1'b0, REG_STATUS, 32'h0); while (rd_q[STAT_BUSY] !== 1'b0);
    rdchk(9'h005, 9'h1FF);
    cmp(32'h0, faults);
    print_verdict();
  end
endmodule
